//--- src/scp_map.svh
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
//------------------------------------------------------------
// Constants of the serial configuration port
//------------------------------------------------------------
`define SCP_ADDR_W 7
`define SCP_DATA_W 8
`define SCP_FRAME_BITS 5'h10
`define SCP_DIR_BIT_IDX 5'h07
`define SCP_LAST_BIT_IDX 5'h0f
`define SCP_CFG_FRAMES 33
`define SCP_PCLK_DIV 4
`define SCP_SEL_GAP_CYC 4
`endif

//--- src/scp_pkg.sv
package scp_pkg;
  // Host sequencer states
  typedef enum logic [1:0] {scp_idle_type_s, scp_shift_s, scp_gap_s} scp_host_state_type;
endpackage

//--- src/scp_link_if.sv
`timescale 1ns/10ps
// Four-wire link; data out may be tied to data in by the bench
interface scp_link_if;
  logic sel_n;          // Select, active low
  logic sclk;           // Serial clock from host
  logic serial_data_in; // Host to device data
  logic serial_data_out;    // Device data out value
  logic serial_data_out_oe_n; // Device drives when low
  logic lock_n;         // Lock status, or carrier sense when lock_sel_cs_in is high; low when asserted
  modport dev (input sel_n, input sclk, input serial_data_in,
    output serial_data_out, output serial_data_out_oe_n, output lock_n);
  modport host (output sel_n, output sclk, output serial_data_in,
    input serial_data_out, input serial_data_out_oe_n, input lock_n);
endinterface

//--- src/scp_sync2.sv
`timescale 1ns/10ps
// Two-flop level synchroniser
module scp_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff; // First stage, read only by second
  //------------------------------------------------------------
  // Two stages
  //------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      q_out <= '0;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end
endmodule

//--- src/scp_device.sv
`timescale 1ns/10ps
`include "scp_map.svh"
// Device end: clocked by the link clock only
module scp_device import scp_pkg::*; #(
  parameter int NUM_REGS = 128
) (
  // Link
  scp_link_if.dev link,
  // Power-on reset, no effect on register contents
  input wire logic rst_in,
  // Status from synthesizer
  input wire logic pll_locked_in,
  input wire logic carrier_sense_in,
  input wire logic lock_sel_cs_in
);
  initial begin
    if (NUM_REGS < 1 || NUM_REGS > 128) $error("NUM_REGS out of range");
  end
  logic [`SCP_DATA_W-1:0] cfg_mem [NUM_REGS]; // Configuration store
  logic [4:0] bit_cnt_ff; // Bits received this frame
  logic [`SCP_ADDR_W:0] hdr_ff; // Address and direction
  logic [`SCP_DATA_W-2:0] wdat_ff; // Write data bits so far
  logic [`SCP_DATA_W-1:0] rd_sh_ff; // Read shift register
  logic rd_act_ff; // Read data phase
  logic out_ff;
  logic oe_n_ff;
  logic lock_n_ff;
  // Decodes
  wire frame_rst = rst_in | link.sel_n; // Select high aborts
  wire [`SCP_ADDR_W-1:0] cur_addr = hdr_ff[`SCP_ADDR_W:1];
  wire dir_now = link.serial_data_in;
  wire at_dir = (bit_cnt_ff == `SCP_DIR_BIT_IDX);
  wire at_last = (bit_cnt_ff == `SCP_LAST_BIT_IDX);
  wire wr_frame = hdr_ff[0];
  wire addr_ok = (32'(cur_addr) < NUM_REGS);
  //------------------------------------------------------------
  // Receive on rising clock
  //------------------------------------------------------------
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_ff <= 5'h00;
      hdr_ff <= '0;
      wdat_ff <= '0;
    end else begin
      if (bit_cnt_ff != `SCP_FRAME_BITS) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
      if (bit_cnt_ff <= `SCP_DIR_BIT_IDX) begin
        hdr_ff <= {hdr_ff[`SCP_ADDR_W-1:0], link.serial_data_in}; // MSB first
      end else begin
        wdat_ff <= {wdat_ff[`SCP_DATA_W-3:0], link.serial_data_in};
      end
    end
  end
  // Store write; no reset so contents survive power-down
  always_ff @(posedge link.sclk) begin
    if (!link.sel_n && at_last && wr_frame && addr_ok) begin
      cfg_mem[cur_addr] <= {wdat_ff, link.serial_data_in}; // Any order
    end
  end
  //------------------------------------------------------------
  // Transmit on falling clock
  //------------------------------------------------------------
  // Direction sampled at rising edge index 7; first data bit leaves on next fall
  logic rd_go_ff;
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      rd_go_ff <= 1'b0;
    end else begin
      rd_go_ff <= at_dir && !dir_now; // Low direction reads
    end
  end
  wire [`SCP_DATA_W-1:0] rd_word = addr_ok ? cfg_mem[cur_addr] : 8'h00;
  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      rd_sh_ff <= '0;
      rd_act_ff <= 1'b0;
      out_ff <= 1'b0;
      oe_n_ff <= 1'b1; // Released while unselected
    end else if (rd_go_ff && !rd_act_ff) begin
      rd_sh_ff <= {rd_word[`SCP_DATA_W-2:0], 1'b0};
      out_ff <= rd_word[`SCP_DATA_W-1];
      oe_n_ff <= 1'b0;
      rd_act_ff <= 1'b1;
    end else if (rd_act_ff && bit_cnt_ff == `SCP_FRAME_BITS) begin
      oe_n_ff <= 1'b1; // Release after last bit
      rd_act_ff <= 1'b0;
    end else if (rd_act_ff) begin
      out_ff <= rd_sh_ff[`SCP_DATA_W-1];
      rd_sh_ff <= {rd_sh_ff[`SCP_DATA_W-2:0], 1'b0};
    end
  end
  //------------------------------------------------------------
  // Lock status, sampled on the link clock
  //------------------------------------------------------------
  logic [1:0] stat_s;
  scp_sync2 #(.WIDTH(2)) u_stat (.clk_in(link.sclk), .rst_in(rst_in),
    .d_in({carrier_sense_in, pll_locked_in}), .q_out(stat_s));
  always_ff @(posedge link.sclk or posedge rst_in) begin
    if (rst_in) begin
      lock_n_ff <= 1'b1;
    end else begin
      lock_n_ff <= lock_sel_cs_in ? !stat_s[1] : !stat_s[0]; // Low when the selected status (lock, or carrier sense if lock_sel_cs_in) is high
    end
  end
  assign link.serial_data_out = out_ff;
  assign link.serial_data_out_oe_n = oe_n_ff;
  assign link.lock_n = lock_n_ff;
endmodule

//--- src/scp_host.sv
`timescale 1ns/10ps
`include "scp_map.svh"
// Host end: makes the link clock from clk_in by a divider
module scp_host import scp_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Command
  input wire logic req_in,
  input wire logic wr_in,
  input wire logic [`SCP_ADDR_W-1:0] addr_in,
  input wire logic [`SCP_DATA_W-1:0] wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [`SCP_DATA_W-1:0] rdata_out,
  output logic locked_out,
  // Link
  scp_link_if.host link
);
  scp_host_state_type state_ff;
  logic [15:0] frame_ff; // Outgoing frame
  logic [4:0] bit_cnt_ff;
  logic [3:0] div_ff; // Clock phase counter
  logic sclk_ff, sel_n_ff, sdi_ff, busy_ff, done_ff;
  logic [`SCP_DATA_W-1:0] rdat_ff;
  logic lock_s;
  logic [3:0] gap_ff;
  logic sdo_s; // Read data after the synchroniser
  scp_sync2 #(.WIDTH(1)) u_lk (.clk_in(clk_in), .rst_in(rst_in), .d_in(link.lock_n), .q_out(lock_s));
  scp_sync2 #(.WIDTH(1)) u_do (.clk_in(clk_in), .rst_in(rst_in), .d_in(link.serial_data_out), .q_out(sdo_s));
  wire half = (div_ff == 4'(`SCP_PCLK_DIV - 1));
  wire rise = half && !sclk_ff;
  wire fall = half && sclk_ff;
  //------------------------------------------------------------
  // Frame sequencer
  //------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= scp_idle_type_s;
      frame_ff <= '0;
      bit_cnt_ff <= '0;
      div_ff <= '0;
      sclk_ff <= 1'b0;
      sel_n_ff <= 1'b1;
      sdi_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rdat_ff <= '0;
      gap_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        scp_idle_type_s: if (req_in) begin
          frame_ff <= {addr_in, wr_in, wdata_in};
          sel_n_ff <= 1'b0; // Held low whole frame
          sdi_ff <= addr_in[`SCP_ADDR_W-1];
          bit_cnt_ff <= '0; div_ff <= '0; busy_ff <= 1'b1;
          state_ff <= scp_shift_s;
        end
        scp_shift_s: begin
          div_ff <= half ? 4'h0 : div_ff + 4'h1;
          if (rise) begin
            sclk_ff <= 1'b1;
            // Read bit delayed by sync; slow clock keeps it valid
            if (bit_cnt_ff > `SCP_DIR_BIT_IDX) rdat_ff <= {rdat_ff[6:0], sdo_s};
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
          end else if (fall) begin
            sclk_ff <= 1'b0;
            frame_ff <= {frame_ff[14:0], 1'b0};
            sdi_ff <= frame_ff[14]; // Change on falling edge
            if (bit_cnt_ff == `SCP_FRAME_BITS) begin
              sel_n_ff <= 1'b1; // High between frames
              gap_ff <= 4'(`SCP_SEL_GAP_CYC);
              state_ff <= scp_gap_s;
            end
          end
        end
        scp_gap_s: if (gap_ff == 4'h0) begin
          busy_ff <= 1'b0; done_ff <= 1'b1; state_ff <= scp_idle_type_s;
        end else begin
          gap_ff <= gap_ff - 4'h1;
        end
        default: state_ff <= scp_idle_type_s;
      endcase
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) locked_out <= 1'b0;
    else locked_out <= !lock_s;
  end
  assign busy_out = busy_ff;
  assign done_out = done_ff;
  assign rdata_out = rdat_ff;
  assign link.sclk = sclk_ff;
  assign link.sel_n = sel_n_ff;
  assign link.serial_data_in = sdi_ff;
endmodule

//--- bench/scp_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------
// Link checker on the wire signals
// ----------------------------------------
module scp_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link wires
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n,
  input wire logic lock_n
);
  logic [4:0] cnt_ff; // Bits seen this frame
  logic dir_ff; // Direction bit of this frame
  // Select high clears the count, no clock edge needed
  always_ff @(posedge sclk or posedge sel_n) begin
    if (sel_n) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end
  // Direction bit arrives on the eighth rise
  always_ff @(posedge sclk) begin
    if (cnt_ff == 5'h07) begin
      dir_ff <= serial_data_in;
    end
  end
  oe_idle_a: assert property (@(posedge clk_in) disable iff (rst_in) sel_n |-> serial_data_out_oe_n)
    else $error("data out driven while deselected");
  sclk_sel_a: assert property (@(posedge clk_in) disable iff (rst_in) $rose(sclk) |-> !sel_n)
    else $error("clock rose outside a frame");
  sel_gap_a: assert property (@(posedge clk_in) disable iff (rst_in) $rose(sel_n) |-> sel_n [*5])
    else $error("select high too short");
  sdi_edge_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !sel_n && $past(!sel_n) && $changed(serial_data_in) |-> $fell(sclk))
    else $error("data in changed off the falling clock");
  sclk_rate_a: assert property (@(posedge clk_in) disable iff (rst_in) $rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("clock high phase wrong");
  frame_len_a: assert property (@(posedge clk_in) disable iff (rst_in) $rose(sel_n) |-> $past(cnt_ff) == 5'h10)
    else $error("frame not sixteen bits");
  oe_read_a: assert property (@(posedge sclk) disable iff (rst_in)
    !sel_n && cnt_ff >= 5'h08 && !dir_ff |-> !serial_data_out_oe_n)
    else $error("read data not driven");
  oe_write_a: assert property (@(posedge sclk) disable iff (rst_in)
    !sel_n && (cnt_ff < 5'h08 || dir_ff) |-> serial_data_out_oe_n)
    else $error("data out driven outside read data");
  // Main scenarios reached
  cover property (@(posedge clk_in) disable iff (rst_in) $rose(sel_n) && dir_ff);
  cover property (@(posedge clk_in) disable iff (rst_in) $rose(sel_n) && !dir_ff);
  cover property (@(posedge clk_in) disable iff (rst_in) $fell(lock_n));
endmodule

//--- bench/tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_in = 1'b0;
  logic wr_in = 1'b0;
  logic [6:0] addr_in = 7'h00;
  logic [7:0] wdata_in = 8'h00;
  logic pll_locked_in = 1'b0;
  logic carrier_sense_in = 1'b0;
  logic lock_sel_cs_in = 1'b0;
  logic busy_out, done_out, locked_out;
  logic [7:0] rdata_out;
  logic [15:0] sh; // Frame as seen on data in
  logic [7:0] ro; // Read data as seen on data out
  logic [7:0] shadow [0:127]; // Expected register contents
  int err_total = 0;
  int comparisons = 0;
  always #2.5 clk_in = ~clk_in;
  scp_link_if u_scp_link_if ();
  scp_host u_scp_host (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .wr_in(wr_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out),
    .locked_out(locked_out), .link(u_scp_link_if.host));
  scp_device #(.NUM_REGS(128)) u_scp_device (.link(u_scp_link_if.dev), .rst_in(rst_in),
    .pll_locked_in(pll_locked_in), .carrier_sense_in(carrier_sense_in), .lock_sel_cs_in(lock_sel_cs_in));
  scp_monitor u_scp_monitor (.clk_in(clk_in), .rst_in(rst_in), .sel_n(u_scp_link_if.sel_n),
    .sclk(u_scp_link_if.sclk), .serial_data_in(u_scp_link_if.serial_data_in),
    .serial_data_out(u_scp_link_if.serial_data_out),
    .serial_data_out_oe_n(u_scp_link_if.serial_data_out_oe_n), .lock_n(u_scp_link_if.lock_n));
  // Bench samples the wire on rising clock, as the device does
  always @(posedge u_scp_link_if.sclk) begin
    if (!u_scp_link_if.sel_n) begin
      sh <= {sh[14:0], u_scp_link_if.serial_data_in};
      if (!u_scp_link_if.serial_data_out_oe_n) begin
        ro <= {ro[6:0], u_scp_link_if.serial_data_out};
      end
    end
  end
  // ----------------------------------------
  // Frame tasks
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    req_in <= 1'b1;
    wr_in <= w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    req_in <= 1'b0;
    #1;
    `CHK("busy high", 1'b1, busy_out)
    // Bounded wait for the one-cycle done pulse
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (done_out !== 1'b1 && n < 400);
    `CHK("done", 1'b1, done_out)
    `CHK("busy low", 1'b0, busy_out)
    `CHK("header", {a, w}, sh[15:8])
    if (w) begin
      `CHK("wire data", d, sh[7:0])
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    shadow[a] = d;
  endtask
  task automatic rd(input logic [6:0] a);
    xfer(1'b0, a, 8'h00);
    `CHK("read data", shadow[a], rdata_out)
    `CHK("wire read data", shadow[a], ro)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Full setup in scrambled order, then read back in reverse
  task automatic t_config;
    for (int i = 0; i < 33; i++) begin
      wr(7'((i * 37 + 5) % 128), 8'(i * 7) ^ 8'ha5);
    end
    for (int i = 32; i >= 0; i--) begin
      rd(7'((i * 37 + 5) % 128));
    end
    $display("t_config done");
  endtask
  // Single write, then a write cut by reset mid-frame; old contents must survive
  task automatic t_powerdown;
    wr(7'h7f, 8'h3c);
    @(posedge clk_in);
    req_in <= 1'b1;
    wr_in <= 1'b1;
    addr_in <= 7'h7f;
    wdata_in <= 8'hc3;
    @(posedge clk_in);
    req_in <= 1'b0;
    // Roughly twelve bits in, inside the data field
    repeat (100) @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(7'h7f);
    rd(7'h05);
    $display("t_powerdown done");
  endtask
  // Lock pin in both modes; it only moves while frames clock it
  task automatic t_lock;
    logic [3:0] tbl [4] = '{4'b1000, 4'b0001, 4'b0110, 4'b1011};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      {pll_locked_in, carrier_sense_in, lock_sel_cs_in} <= tbl[i][3:1];
      rd(7'h7f);
      rd(7'h7f);
      repeat (4) @(posedge clk_in);
      #1;
      `CHK("lock pin", tbl[i][0], u_scp_link_if.lock_n)
      `CHK("locked", ~tbl[i][0], locked_out)
    end
    $display("t_lock done");
  endtask
  task conclude;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_config;
    t_powerdown;
    t_lock;
    conclude;
  end
  // Watchdog, well beyond some eighty frames
  initial begin
    #300000;
    err_total++;
    conclude;
  end
endmodule
